// ===== dv/sensor_model.sv
`timescale 1ns/1ns
module sensor_model (
  input wire logic i_clock,
  input wire logic [3:0] i_mux,
  input wire logic [9:0] i_dac,
  input wire logic i_sample,
  input wire logic [89:0] i_codes,
  output logic o_comp
);
  logic [9:0] live;
  logic [9:0] held_reg;

  // Unused mux codes read as full scale so a stray select is visible
  always_comb begin
    live = (i_mux < 4'h9) ? i_codes[i_mux*10 +: 10] : 10'h3FF;
  end

  // Track and hold: the input is frozen once the sample slot ends
  always_ff @(posedge i_clock) begin
    if (i_sample) begin
      held_reg <= live;
    end
  end

  always_comb begin
    o_comp = ((i_sample ? live : held_reg) >= i_dac);
  end
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ns
module tb;
  import thermal_pkg::*;
  localparam int FILT = 8;
  logic clk = 0, rst = 1;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic sd1r = 0, sd1g = 0, sd2r = 0;
  logic [89:0] codes;
  logic awready, wready, bvalid, arready, rvalid, comp, smp, reg_off, rlow, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] mux;
  logic [9:0] dac;
  logic [5:0] off;
  int fails = 0, total_checks = 0;

  thermal_cluster_supervisor #(.FILTER_CYC(FILT)) uut (.i_clock(clk), .i_reset(rst),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .i_adc_comp(comp), .o_adc_mux(mux), .o_adc_dac(dac),
    .o_adc_sample(smp), .i_regulator_heat_zone_sd1(sd1r), .i_global_heat_zone_sd1(sd1g),
    .i_regulator_heat_zone_sd2(sd2r), .o_cluster_off(off), .o_gate_resistive_low(rlow),
    .o_main_regulator_off(reg_off), .o_irq(irq));

  sensor_model model (.i_clock(clk), .i_mux(mux), .i_dac(dac), .i_sample(smp),
    .i_codes(codes), .o_comp(comp));

  always #10 clk = ~clk;

  function automatic logic [9:0] temp_code(input int t);
    return 10'($rtoi((350.0 - t) / 0.488 + 0.5));
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask

  task automatic wait_bit(input int b);
    logic [31:0] d;
    logic [1:0] r;
    for (int n = 0; n < 300; n++) begin
      rd(OFS_STATUS, d, r);
      if (d[b] === 1'b1) break;
    end
    chk(d[b], 1, "status flag");
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(OFS_CONTROL, d, r);
    chk(d, 0, "control default");
    rd(OFS_MASK, d, r);
    chk(d, 0, "mask default");
    rd(OFS_THRESH, d, r);
    chk(d, {6'h0, SD_CODE_RST, 6'h0, WARN_CODE_RST}, "thresholds");
    rd(OFS_STATUS, d, r);
    chk(d, 0, "flags clear");
    chk({rlow, reg_off, irq, off}, 0, "outputs idle");
    rd(8'h40, d, r);
    chk(r, RESP_SLVERR, "unmapped read response");
    chk(d, 0, "unmapped read data");
    wr(OFS_RESULT, 32'h1, r);
    chk(r, RESP_SLVERR, "result is read only");
    $display("test reset done");
  endtask

  task automatic t_results;
    logic [31:0] d;
    logic [1:0] r;
    repeat (420) @(posedge clk);
    for (int k = 0; k < 9; k++) begin
      rd(8'(OFS_RESULT + 4 * k), d, r);
      chk(d, {22'h0, codes[k*10 +: 10]}, "conversion result");
    end
    $display("test results done");
  endtask

  task automatic t_standard;
    logic [1:0] r;
    codes[30 +: 10] <= 10'h100;
    wait_bit(ST_WARN_LSB);
    wait_bit(ST_SD1_LSB);
    repeat (3) @(posedge clk);
    chk({rlow, reg_off, off}, {2'b10, 6'h3F}, "standard mode all off");
    wr(OFS_MASK, 32'h100, r);
    repeat (2) @(posedge clk);
    chk(irq, 1, "irq unmasked");
    wr(OFS_MASK, 32'h0, r);
    repeat (2) @(posedge clk);
    chk(irq, 0, "irq masked");
    $display("test standard done");
  endtask

  task automatic t_clear;
    logic [31:0] d;
    logic [1:0] r;
    wr(OFS_STATUS, 32'h1, r);
    rd(OFS_STATUS, d, r);
    chk(d[8], 1, "unwritten bit kept");
    repeat (3) @(posedge clk);
    chk(off, 6'h3F, "still off");
    wr(OFS_STATUS, 32'h101, r);
    repeat (3) @(posedge clk);
    for (int n = 0; n < 2 * FILT - 4; n++) begin
      @(posedge clk);
      chk(off, 0, "back on while hot");
    end
    wait_bit(ST_SD1_LSB);
    codes[30 +: 10] <= temp_code(25);
    repeat (420) @(posedge clk);
    wr(OFS_STATUS, ST_USED_MASK, r);
    repeat (3) @(posedge clk);
    chk({rlow, off}, 0, "released after clear");
    $display("test clear done");
  endtask

  task automatic t_cluster;
    logic [1:0] r;
    wr(OFS_CONTROL, 32'h1, r);
    codes[50 +: 10] <= 10'h100;
    wait_bit(ST_SD1_LSB + 2);
    repeat (3) @(posedge clk);
    chk(off, 6'h04, "only hot zone off");
    codes[50 +: 10] <= temp_code(25);
    repeat (420) @(posedge clk);
    wr(OFS_STATUS, ST_USED_MASK, r);
    $display("test cluster done");
  endtask

  task automatic t_analog;
    logic [31:0] d;
    logic [1:0] r;
    for (int z = REG_ZONE; z <= GLOB_ZONE; z++) begin
      codes[(3 + z)*10 +: 10] <= 10'h100;
      sd1r <= (z == REG_ZONE);
      sd1g <= (z == GLOB_ZONE);
      wait_bit(ST_SD1_LSB + z);
      repeat (3) @(posedge clk);
      chk({reg_off, off}, 7'h3F, "hot supply zone all off");
      codes[(3 + z)*10 +: 10] <= temp_code(25);
      sd1r <= 0;
      sd1g <= 0;
      repeat (420) @(posedge clk);
      wr(OFS_STATUS, ST_USED_MASK, r);
    end
    sd2r <= 1;
    repeat (FILT / 2) @(posedge clk);
    sd2r <= 0;
    repeat (20) @(posedge clk);
    rd(OFS_STATUS, d, r);
    chk(d[ST_SD2_BIT], 0, "short excursion ignored");
    sd2r <= 1;
    wait_bit(ST_SD2_BIT);
    repeat (3) @(posedge clk);
    chk(reg_off, 1, "regulator off at level two");
    sd2r <= 0;
    wr(OFS_STATUS, ST_USED_MASK, r);
    repeat (3) @(posedge clk);
    chk(reg_off, 0, "regulator back");
    $display("test analog done");
  endtask

  task automatic end_sim;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    codes = {temp_code(25), temp_code(30), temp_code(40), temp_code(50), temp_code(60),
             temp_code(70), 10'h0F0, 10'h155, 10'h2AB};
    repeat (12) @(posedge clk);
    rst <= 0;
    t_reset;
    t_results;
    t_standard;
    t_clear;
    t_cluster;
    t_analog;
    end_sim;
  end

  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    end_sim;
  end
endmodule

// ===== rtl/sar_sequencer.sv
`timescale 1ns/1ns
module sar_sequencer
  import thermal_pkg::*;
#(
  parameter int BITS = ADC_BITS,
  parameter int CHANNELS = NUM_CHANNELS,
  parameter int DIV = CONV_CLK_DIV
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_comp,
  output logic [3:0] o_mux_sel,
  output logic [BITS-1:0] o_dac_code,
  output logic o_sample,
  output logic o_valid,
  output logic [3:0] o_chan,
  output logic [BITS-1:0] o_data
);
  localparam int DW = $clog2(DIV + 1);
  localparam int BW = $clog2(BITS);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);
  localparam logic [3:0] CH_LAST = 4'(CHANNELS - 1);
  localparam logic [BW-1:0] BIT_TOP = BW'(BITS - 1);
  localparam logic [BITS-1:0] MSB_ONLY = {1'b1, {(BITS - 1){1'b0}}};

  sar_state_e state_reg;
  logic [DW-1:0] div_reg;
  logic [BW-1:0] bit_reg;
  logic tick;

  assign tick = div_reg == DIV_LAST;
  assign o_sample = state_reg == SAR_SAMPLE;

  // Converter clock is a divided enable of the main clock
  always_ff @(posedge i_clock) begin
    if (i_reset || tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // One sample slot then one bit decision per converter tick
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_reg <= SAR_SAMPLE;
      bit_reg <= '0;
      o_dac_code <= MSB_ONLY;
      o_mux_sel <= '0;
      o_valid <= 1'b0;
      o_chan <= '0;
      o_data <= '0;
    end else begin
      o_valid <= 1'b0;
      if (tick) begin
        case (state_reg)
          SAR_SAMPLE: begin
            state_reg <= SAR_CONVERT;
            bit_reg <= BIT_TOP;
            o_dac_code <= MSB_ONLY;
          end
          SAR_CONVERT: begin
            if (bit_reg == '0) begin
              o_data <= {o_dac_code[BITS-1:1], i_comp};
              o_valid <= 1'b1;
              o_chan <= o_mux_sel;
              o_mux_sel <= (o_mux_sel == CH_LAST) ? 4'h0 : o_mux_sel + 4'h1; // see RQ13
              state_reg <= SAR_SAMPLE;
            end else begin
              o_dac_code[bit_reg] <= i_comp; // see RQ12
              o_dac_code[bit_reg - 1'b1] <= 1'b1;
              bit_reg <= bit_reg - 1'b1;
            end
          end
          default: begin
            state_reg <= SAR_SAMPLE;
          end
        endcase
      end
    end
  end
endmodule

// ===== rtl/thermal_cluster_supervisor.sv
`timescale 1ns/1ns
// Function
// RQ1: Sustained warning excursion sets sticky warning flag
// RQ2: Sustained shutdown excursion sets flag, stages off
// RQ3: Shutdown puts gate drivers in resistive low
// RQ4: Outputs stay off until host clears flags
// RQ5: Shutdown filter starts only after warning flag
// RQ6: Six zones, each with sensor and flags
// RQ7: Cluster mode switches off only hot zone
// RQ8: Standard mode switches all; regulator needs level two
// RQ9: Regulator or global zone switches all off
// RQ10: Temperature reported as raw inverse code
// RQ11: Zones 1-4 digital, 5-6 analog shutdown
// RQ12: Single 10-bit SAR converter on converter clock
// RQ13: Nine channels converted in fixed rotation
// RQ14: Clear only status bits written as one
// RQ15: Filter restarts when excursion ends early
module thermal_cluster_supervisor
  import thermal_pkg::*;
#(
  parameter int FILTER_CYC = FILTER_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_adc_comp,
  output logic [3:0] o_adc_mux,
  output logic [ADC_BITS-1:0] o_adc_dac,
  output logic o_adc_sample,
  input wire logic i_regulator_heat_zone_sd1,
  input wire logic i_global_heat_zone_sd1,
  input wire logic i_regulator_heat_zone_sd2,
  output logic [NUM_ZONES-1:0] o_cluster_off,
  output logic o_gate_resistive_low,
  output logic o_main_regulator_off,
  output logic o_irq
);
  localparam int CW = $clog2(FILTER_CYC + 1);
  localparam logic [CW-1:0] FMAX = CW'(FILTER_CYC - 1);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction

  logic aw_held_reg, w_held_reg, wr_go;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic cluster_mode_select_reg;
  logic [31:0] mask_reg;
  logic [ADC_BITS-1:0] warn_thr_reg, sd_thr_reg;
  logic [ADC_BITS-1:0] res_reg [NUM_CHANNELS];
  logic [NUM_ZONES-1:0] temp_warn_flag_reg, shutdown_level_one_reg;
  logic shutdown_level_two_reg;
  logic [NUM_ZONES-1:0] warn_evt, sd1_evt, hot_warn, hot_sd, off_latch_reg;
  logic sd2_evt;
  logic [CW-1:0] sd2_cnt_reg;
  logic [31:0] status_word, thresh_word, status_clr, rd_data, thresh_merged;
  logic rd_ok;
  logic adc_valid;
  logic [3:0] adc_chan;
  logic [ADC_BITS-1:0] adc_data;
  logic [5:0] res_idx;
  logic global_down;

  sar_sequencer u_sar (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_comp(i_adc_comp),
    .o_mux_sel(o_adc_mux),
    .o_dac_code(o_adc_dac),
    .o_sample(o_adc_sample),
    .o_valid(adc_valid),
    .o_chan(adc_chan),
    .o_data(adc_data)
  );

  // Latest result per channel; codes are stored as converted
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      for (int k = 0; k < NUM_CHANNELS; k++) begin
        res_reg[k] <= RESULT_RST;
      end
    end else if (adc_valid) begin
      res_reg[adc_chan] <= adc_data; // see RQ10
    end
  end

  // Higher temperature gives a lower code, so hot means below threshold
  for (genvar i = 0; i < NUM_ZONES; i++) begin : g_zone
    logic [CW-1:0] wcnt_reg, scnt_reg;
    logic sd_cond;
    assign hot_warn[i] = res_reg[FIRST_ZONE_CH + i] < warn_thr_reg; // see RQ6
    if (i < NUM_DIGITAL_ZONES) begin : g_dig
      assign sd_cond = res_reg[FIRST_ZONE_CH + i] < sd_thr_reg; // see RQ11
    end else if (i == REG_ZONE) begin : g_reg
      assign sd_cond = i_regulator_heat_zone_sd1; // see RQ11
    end else begin : g_glob
      assign sd_cond = i_global_heat_zone_sd1;
    end
    assign hot_sd[i] = sd_cond && temp_warn_flag_reg[i]; // see RQ5
    always_ff @(posedge i_clock) begin
      if (i_reset || !hot_warn[i] || temp_warn_flag_reg[i]) begin
        wcnt_reg <= '0; // see RQ15
      end else if (wcnt_reg != FMAX) begin
        wcnt_reg <= wcnt_reg + 1'b1;
      end
    end
    always_ff @(posedge i_clock) begin
      if (i_reset || !hot_sd[i] || shutdown_level_one_reg[i]) begin
        scnt_reg <= '0; // see RQ15
      end else if (scnt_reg != FMAX) begin
        scnt_reg <= scnt_reg + 1'b1;
      end
    end
    assign warn_evt[i] = hot_warn[i] && !temp_warn_flag_reg[i] && wcnt_reg == FMAX; // see RQ1
    assign sd1_evt[i] = hot_sd[i] && !shutdown_level_one_reg[i] && scnt_reg == FMAX; // see RQ2
  end

  always_ff @(posedge i_clock) begin
    if (i_reset || !i_regulator_heat_zone_sd2 || shutdown_level_two_reg) begin
      sd2_cnt_reg <= '0;
    end else if (sd2_cnt_reg != FMAX) begin
      sd2_cnt_reg <= sd2_cnt_reg + 1'b1;
    end
  end
  assign sd2_evt = i_regulator_heat_zone_sd2 && !shutdown_level_two_reg && sd2_cnt_reg == FMAX;

  assign status_clr = (wr_go && waddr_reg[7:2] == OFS_STATUS[7:2]) ?
                      merge(32'h0, wdata_reg, wstrb_reg) : 32'h0;

  // A new event in the clearing cycle wins over the clear
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      temp_warn_flag_reg <= '0;
      shutdown_level_one_reg <= '0;
      shutdown_level_two_reg <= 1'b0;
    end else begin
      temp_warn_flag_reg <= (temp_warn_flag_reg & ~status_clr[ST_WARN_LSB +: NUM_ZONES])
                            | warn_evt; // see RQ14
      shutdown_level_one_reg <= (shutdown_level_one_reg & ~status_clr[ST_SD1_LSB +: NUM_ZONES])
                                | sd1_evt; // see RQ14
      shutdown_level_two_reg <= (shutdown_level_two_reg & ~status_clr[ST_SD2_BIT]) | sd2_evt;
    end
  end

  // Latch holds a zone down until both of its flags are gone
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      off_latch_reg <= '0;
    end else begin
      off_latch_reg <= shutdown_level_one_reg | (off_latch_reg & temp_warn_flag_reg); // see RQ4
    end
  end

  assign global_down = off_latch_reg[REG_ZONE] || off_latch_reg[GLOB_ZONE] // see RQ9
                       || (!cluster_mode_select_reg && |off_latch_reg); // see RQ8

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_cluster_off <= '0;
      o_gate_resistive_low <= 1'b0;
      o_main_regulator_off <= 1'b0;
    end else begin
      o_cluster_off <= {NUM_ZONES{global_down}} | off_latch_reg; // see RQ7
      o_gate_resistive_low <= |off_latch_reg; // see RQ3
      o_main_regulator_off <= shutdown_level_two_reg; // see RQ8
    end
  end

  always_comb begin
    status_word = 32'h0;
    status_word[ST_WARN_LSB +: NUM_ZONES] = temp_warn_flag_reg;
    status_word[ST_SD1_LSB +: NUM_ZONES] = shutdown_level_one_reg;
    status_word[ST_SD2_BIT] = shutdown_level_two_reg;
    thresh_word = 32'h0;
    thresh_word[TH_WARN_LSB +: ADC_BITS] = warn_thr_reg;
    thresh_word[TH_SD_LSB +: ADC_BITS] = sd_thr_reg;
  end

  assign o_irq = |(status_word & mask_reg);

  // Write channel: address and data accepted in either order
  assign o_awready = !aw_held_reg && !o_bvalid;
  assign o_wready = !w_held_reg && !o_bvalid;
  assign wr_go = aw_held_reg && w_held_reg;
  assign thresh_merged = merge(thresh_word, wdata_reg, wstrb_reg);

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_held_reg <= 1'b1;
        waddr_reg <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (waddr_reg[7:2] <= OFS_THRESH[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cluster_mode_select_reg <= 1'b0;
      mask_reg <= 32'h0;
      warn_thr_reg <= WARN_CODE_RST;
      sd_thr_reg <= SD_CODE_RST;
    end else if (wr_go) begin
      case (waddr_reg[7:2])
        OFS_CONTROL[7:2]: begin
          cluster_mode_select_reg <= wstrb_reg[CTRL_MODE_BIT / 8] ? wdata_reg[CTRL_MODE_BIT]
                                                                 : cluster_mode_select_reg;
        end
        OFS_MASK[7:2]: begin
          mask_reg <= merge(mask_reg, wdata_reg, wstrb_reg) & ST_USED_MASK;
        end
        OFS_THRESH[7:2]: begin
          warn_thr_reg <= thresh_merged[TH_WARN_LSB +: ADC_BITS];
          sd_thr_reg <= thresh_merged[TH_SD_LSB +: ADC_BITS];
        end
        default: begin
        end
      endcase
    end
  end

  // Read channel: one word per register, results follow the control words
  assign o_arready = !o_rvalid;
  assign res_idx = i_araddr[7:2] - OFS_RESULT[7:2];

  always_comb begin
    rd_data = 32'h0;
    rd_ok = 1'b1;
    case (i_araddr[7:2])
      OFS_CONTROL[7:2]: rd_data[CTRL_MODE_BIT] = cluster_mode_select_reg;
      OFS_STATUS[7:2]: rd_data = status_word;
      OFS_MASK[7:2]: rd_data = mask_reg;
      OFS_THRESH[7:2]: rd_data = thresh_word;
      default: begin
        if (i_araddr[7:2] >= OFS_RESULT[7:2] && res_idx < 6'(NUM_CHANNELS)) begin
          rd_data[ADC_BITS-1:0] = res_reg[res_idx[3:0]];
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata <= rd_data;
      o_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  property p_warn_filter;
    @(posedge i_clock) disable iff (i_reset)
    warn_evt[0] |=> temp_warn_flag_reg[0];
  endproperty
  a_warn_filter: assert property (p_warn_filter) else $error("warning flag not set"); // see RQ1

  property p_warn_sustained;
    @(posedge i_clock) disable iff (i_reset)
    $rose(temp_warn_flag_reg[0]) |-> $past(hot_warn[0], 2);
  endproperty
  a_warn_sustained: assert property (p_warn_sustained) else $error("flag without heat"); // see RQ15

  property p_sd1_off;
    @(posedge i_clock) disable iff (i_reset)
    shutdown_level_one_reg[0] |-> ##2 o_cluster_off[0];
  endproperty
  a_sd1_off: assert property (p_sd1_off) else $error("zone not switched off"); // see RQ2

  property p_resistive;
    @(posedge i_clock) disable iff (i_reset)
    |shutdown_level_one_reg |-> ##2 o_gate_resistive_low;
  endproperty
  a_resistive: assert property (p_resistive) else $error("gates not resistive low"); // see RQ3

  property p_reenable;
    @(posedge i_clock) disable iff (i_reset)
    $fell(o_cluster_off[0]) |-> $past(!temp_warn_flag_reg[0] && !shutdown_level_one_reg[0], 2);
  endproperty
  a_reenable: assert property (p_reenable) else $error("zone back on too early"); // see RQ4

  property p_sd_after_warn;
    @(posedge i_clock) disable iff (i_reset)
    $rose(shutdown_level_one_reg[0]) |-> $past(temp_warn_flag_reg[0]);
  endproperty
  a_sd_after_warn: assert property (p_sd_after_warn) else $error("shutdown before warning"); // see RQ5

  property p_cluster_mode;
    @(posedge i_clock) disable iff (i_reset)
    cluster_mode_select_reg && !global_down |=> o_cluster_off == $past(off_latch_reg);
  endproperty
  a_cluster_mode: assert property (p_cluster_mode) else $error("other zone off"); // see RQ7

  property p_std_mode;
    @(posedge i_clock) disable iff (i_reset)
    !cluster_mode_select_reg && |off_latch_reg |=> &o_cluster_off;
  endproperty
  a_std_mode: assert property (p_std_mode) else $error("standard mode partial off"); // see RQ8

  property p_global;
    @(posedge i_clock) disable iff (i_reset)
    off_latch_reg[GLOB_ZONE] || off_latch_reg[REG_ZONE] |=> &o_cluster_off;
  endproperty
  a_global: assert property (p_global) else $error("global zone not all off"); // see RQ9

  property p_selective_clear;
    @(posedge i_clock) disable iff (i_reset)
    wr_go && waddr_reg == OFS_STATUS && wstrb_reg[1] && !wdata_reg[ST_SD1_LSB]
    && shutdown_level_one_reg[0] |=> shutdown_level_one_reg[0];
  endproperty
  a_selective_clear: assert property (p_selective_clear) else $error("bit cleared by zero"); // see RQ14

  property p_rotation;
    @(posedge i_clock) disable iff (i_reset)
    adc_valid && adc_chan == 4'h8 |-> ##[1:30] (adc_valid && adc_chan == 4'h0);
  endproperty
  a_rotation: assert property (p_rotation) else $error("channel rotation broken"); // see RQ13

  c_warn: cover property (@(posedge i_clock) disable iff (i_reset) $rose(temp_warn_flag_reg[2]));
  c_cluster_sd: cover property (@(posedge i_clock) disable iff (i_reset)
                                cluster_mode_select_reg && $rose(o_cluster_off[2]));
  c_level_two: cover property (@(posedge i_clock) disable iff (i_reset) $rose(o_main_regulator_off));
endmodule

// ===== rtl/thermal_pkg.sv
package thermal_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int FILTER_TIME_NS = 100000;
  localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CLK_DIV = 2;
  localparam int ADC_BITS = 10;
  localparam int NUM_CHANNELS = 9;
  localparam int NUM_ZONES = 6;
  localparam int FIRST_ZONE_CH = 3;
  localparam int NUM_DIGITAL_ZONES = 4;
  localparam int REG_ZONE = 4;
  localparam int GLOB_ZONE = 5;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_THRESH = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam int CTRL_MODE_BIT = 0;
  localparam int ST_WARN_LSB = 0;
  localparam int ST_SD1_LSB = 8;
  localparam int ST_SD2_BIT = 16;
  localparam logic [31:0] ST_USED_MASK = 32'h0001_3F3F;
  localparam int TH_WARN_LSB = 0;
  localparam int TH_SD_LSB = 16;
  localparam logic [9:0] WARN_CODE_RST = 10'h19A;
  localparam logic [9:0] SD_CODE_RST = 10'h167;
  localparam logic [9:0] RESULT_RST = 10'h3FF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SAR_SAMPLE = 2'b01,
    SAR_CONVERT = 2'b10
  } sar_state_e;
endpackage
